// ==== design/bsp_port_ctrl.sv ====
// Burst memory port controller: read and write ports, clock lock, byte masks
// Function
// - With PLL enabled, lock comes 100 us after a stable clock, no reset.
// - Both clocks stopped at least 30 ns resets the PLL lock.
// - PLL disable pin low: PLL off, one-cycle read latency mode.
// - Write: select low at K rise takes word 0; K_n rise takes address, word 1.
// - Read: select low at K rise latches address; data 2.5 cycles later with PLL enabled.
// - Burst words go to the latched address, then the next address.
// - After reset both ports idle and read outputs are high impedance.
// - Write data taken and read data launched on rises of both clocks.
// - Narrow mode: byte select 0 writes bits 8:0, select 1 bits 17:9.
// - Narrow mode: both selects high writes nothing for that half.
// - Wide mode: four byte selects write the four 9-bit lanes per half.
// - Wide mode: all four selects high writes nothing for that half.
// - Read deselect: finish pending reads, then high-Z after next K_n rise.
`timescale 1ns/1ps
`default_nettype none
module bsp_port_ctrl (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic k,
	input wire logic k_n,
	input wire logic pll_disable_pin,
	input wire logic cfg_x18,
	input wire logic read_port_select_n,
	input wire logic write_port_select_n,
	input wire logic [bsp_pkg::AW-1:0] addr,
	input wire logic [bsp_pkg::DATA_W-1:0] d,
	input wire logic [bsp_pkg::NBYTE-1:0] byte_write_select_n,
	output logic [bsp_pkg::DATA_W-1:0] q,
	output logic q_oe_n,
	output logic pll_locked,
	output logic wr_ready
);
	localparam int AW = bsp_pkg::AW;
	localparam int DW = bsp_pkg::DATA_W;
	localparam int NB = bsp_pkg::NBYTE;
	localparam int BW = bsp_pkg::BYTE_W;
	localparam int RP = bsp_pkg::RD_PIPE;

	// Pin synchroniser
	logic [bsp_pkg::IN_W-1:0] s1_q, s1_d, s2_q, s2_d;
	logic kp_q, kp_d, knp_q, knp_d;
	logic sk, skn, s_pll_dis, s_x18, s_rps_n, s_wps_n;
	logic [AW-1:0] s_addr;
	logic [DW-1:0] s_d;
	logic [NB-1:0] s_bws_n;

	always_comb begin
		s1_d = {k, k_n, pll_disable_pin, cfg_x18, read_port_select_n,
			write_port_select_n, addr, d, byte_write_select_n};
		s2_d = s1_q;
		kp_d = sk;
		knp_d = skn;
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			s1_q <= bsp_pkg::SYNC_RST;
			s2_q <= bsp_pkg::SYNC_RST;
			kp_q <= 1'b0;
			knp_q <= 1'b0;
		end else begin
			s1_q <= s1_d;
			s2_q <= s2_d;
			kp_q <= kp_d;
			knp_q <= knp_d;
		end
	end

	assign {sk, skn, s_pll_dis, s_x18, s_rps_n, s_wps_n, s_addr, s_d,
		s_bws_n} = s2_q;

	logic k_rise, kn_rise, any_edge, stopped;
	assign k_rise = sk && !kp_q;
	assign kn_rise = skn && !knp_q;
	assign any_edge = k_rise || kn_rise;

	// Clock stop detection and lock timer
	logic [3:0] idle_q, idle_d;
	logic [11:0] lock_q, lock_d;
	logic locked_q, locked_d;
	logic ops_en;

	// A clk cycle with no edge counts as stopped
	assign stopped = !any_edge && (idle_q >= 4'(bsp_pkg::STOP_CYC - 1'b1));
	// Legacy mode runs without waiting for lock
	assign ops_en = !s_pll_dis || locked_q;

	always_comb begin
		idle_d = idle_q;
		lock_d = lock_q;
		locked_d = locked_q;
		if (any_edge) begin
			idle_d = '0;
		end else if (idle_q < bsp_pkg::STOP_CYC) begin
			idle_d = 4'(idle_q + 1'b1);
		end
		if (stopped || !s_pll_dis) begin
			lock_d = '0;
			locked_d = 1'b0;
		end else if (!locked_q) begin
			lock_d = 12'(lock_q + 1'b1);
			if (lock_q == 12'(bsp_pkg::LOCK_CYC - 1'b1)) begin
				locked_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			idle_q <= '0;
			lock_q <= '0;
			locked_q <= 1'b0;
		end else begin
			idle_q <= idle_d;
			lock_q <= lock_d;
			locked_q <= locked_d;
		end
	end

	// Write queue between capture and the array
	bsp_fifo_if #(.W(bsp_pkg::FE_W)) wq ();

	bsp_fifo #(.W(bsp_pkg::FE_W), .DEPTH(bsp_pkg::FIFO_DEPTH)) u_wq (
		.clk(clk),
		.reset_n(reset_n),
		.fif(wq)
	);

	// Write capture
	bsp_pkg::bsp_wr_e wst_q, wst_d;
	logic [DW-1:0] w0_q, w0_d;
	logic [NB-1:0] m0_q, m0_d;
	logic push_q, push_d;
	logic [bsp_pkg::FE_W-1:0] entry_q, entry_d;
	logic [NB-1:0] lane_ok, s_mask;

	// Narrow mode keeps the upper two lanes shut
	always_comb begin
		if (s_x18) begin
			lane_ok = bsp_pkg::X18_LANES;
		end else begin
			lane_ok = bsp_pkg::X36_LANES;
		end
	end
	assign s_mask = ~s_bws_n & lane_ok;

	always_comb begin
		wst_d = wst_q;
		w0_d = w0_q;
		m0_d = m0_q;
		push_d = 1'b0;
		entry_d = entry_q;
		case (wst_q)
			bsp_pkg::BSP_WR_IDLE: begin
				// Full queue refuses a new write
				if (k_rise && !s_wps_n && ops_en && wq.in_ready) begin
					w0_d = s_d;
					m0_d = s_mask;
					wst_d = bsp_pkg::BSP_WR_HALF;
				end
			end
			bsp_pkg::BSP_WR_HALF: begin
				if (kn_rise) begin
					entry_d = {s_addr, s_d, s_mask, w0_q, m0_q};
					push_d = 1'b1;
					wst_d = bsp_pkg::BSP_WR_IDLE;
				end
			end
			default: begin
				wst_d = bsp_pkg::BSP_WR_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wst_q <= bsp_pkg::BSP_WR_IDLE;
			w0_q <= '0;
			m0_q <= '0;
			push_q <= 1'b0;
			entry_q <= '0;
		end else begin
			wst_q <= wst_d;
			w0_q <= w0_d;
			m0_q <= m0_d;
			push_q <= push_d;
			entry_q <= entry_d;
		end
	end

	assign wq.in_valid = push_q;
	assign wq.in_data = entry_q;
	// Clock stop stalls the queue drain
	assign wq.out_ready = !stopped;

	// Storage, one array per byte lane
	// Array contents are not reset
	logic pop;
	logic [AW-1:0] wa0, wa1, sel_a;
	logic [DW-1:0] rd_word;
	assign pop = wq.out_valid && wq.out_ready;
	assign wa0 = wq.out_data[bsp_pkg::FE_A_LSB +: AW];
	assign wa1 = AW'(wa0 + 1'b1);

	genvar b;
	generate
		for (b = 0; b < NB; b++) begin : g_lane
			logic [BW-1:0] ln_q [bsp_pkg::MEM_DEPTH];
			logic [BW-1:0] ln_d [bsp_pkg::MEM_DEPTH];
			always_comb begin
				ln_d = ln_q;
				if (pop && wq.out_data[bsp_pkg::FE_M0_LSB + b]) begin
					ln_d[wa0] = wq.out_data[bsp_pkg::FE_W0_LSB + b*BW +: BW];
				end
				if (pop && wq.out_data[bsp_pkg::FE_M1_LSB + b]) begin
					ln_d[wa1] = wq.out_data[bsp_pkg::FE_W1_LSB + b*BW +: BW];
				end
			end
			always_ff @(posedge clk) begin
				ln_q <= ln_d;
			end
			assign rd_word[b*BW +: BW] = ln_q[sel_a];
		end
	endgenerate

	// Read pipeline, advanced on every clock edge
	logic [RP-1:0] rv_q, rv_d;
	logic [AW-1:0] ra_q [RP];
	logic [AW-1:0] ra_d [RP];
	logic [2:0] lat;
	logic [DW-1:0] q_q, q_d, rd_mask;
	logic q_oe_n_q, q_oe_n_d;
	logic locked_out_q, wr_ready_q;

	// Launch slot of word 0 for the selected mode
	always_comb begin
		if (s_pll_dis) begin
			lat = bsp_pkg::LAT_PLL;
		end else begin
			lat = bsp_pkg::LAT_LEGACY;
		end
	end

	// Word 0 reads the latched address, word 1 the next one
	always_comb begin
		if (rv_q[lat - 3'h1]) begin
			sel_a = ra_q[lat - 3'h1];
		end else begin
			sel_a = AW'(ra_q[lat] + 1'b1);
		end
	end

	// Upper lanes read as zero in narrow mode
	always_comb begin
		if (s_x18) begin
			rd_mask = {{(DW-2*BW){1'b0}}, {(2*BW){1'b1}}};
		end else begin
			rd_mask = {DW{1'b1}};
		end
	end

	always_comb begin
		rv_d = rv_q;
		ra_d = ra_q;
		q_d = q_q;
		q_oe_n_d = q_oe_n_q;
		if (any_edge) begin
			rv_d = {rv_q[RP-2:0], k_rise && !s_rps_n && ops_en};
			ra_d[0] = s_addr;
			for (int i = 1; i < RP; i++) begin
				ra_d[i] = ra_q[i-1];
			end
			if (rv_q[lat - 3'h1] || rv_q[lat]) begin
				q_d = rd_word & rd_mask;
				q_oe_n_d = 1'b0;
			end else if (kn_rise) begin
				q_oe_n_d = 1'b1;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			rv_q <= '0;
			q_q <= bsp_pkg::Q_RST;
			q_oe_n_q <= bsp_pkg::Q_OE_N_RST;
			locked_out_q <= 1'b0;
			wr_ready_q <= 1'b0;
		end else begin
			rv_q <= rv_d;
			q_q <= q_d;
			q_oe_n_q <= q_oe_n_d;
			locked_out_q <= locked_q;
			wr_ready_q <= wq.in_ready;
		end
		ra_q <= ra_d;
	end

	assign q = q_q;
	assign q_oe_n = q_oe_n_q;
	assign pll_locked = locked_out_q;
	assign wr_ready = wr_ready_q;
endmodule : bsp_port_ctrl
`default_nettype wire

// ==== design/bsp_pkg.sv ====
// Constants shared by the burst memory port controller and its write queue
package bsp_pkg;
	localparam int DATA_W = 36;
	localparam int BYTE_W = 9;
	localparam int NBYTE = 4;
	localparam int AW = 4;
	localparam int MEM_DEPTH = 16;
	localparam int FIFO_DEPTH = 32;
	localparam int IN_W = 6 + AW + DATA_W + NBYTE;
	// Write queue entry layout
	localparam int FE_M0_LSB = 0;
	localparam int FE_W0_LSB = FE_M0_LSB + NBYTE;
	localparam int FE_M1_LSB = FE_W0_LSB + DATA_W;
	localparam int FE_W1_LSB = FE_M1_LSB + NBYTE;
	localparam int FE_A_LSB = FE_W1_LSB + DATA_W;
	localparam int FE_W = FE_A_LSB + AW;
	// Byte lanes usable in the narrow and wide configurations
	localparam logic [NBYTE-1:0] X18_LANES = 4'h3;
	localparam logic [NBYTE-1:0] X36_LANES = 4'hf;
	// Read launch positions counted in clock-edge slots
	localparam int RD_PIPE = 6;
	localparam logic [2:0] LAT_PLL = 3'h5;
	localparam logic [2:0] LAT_LEGACY = 3'h2;
	// Timing
	localparam int CLK_NS = 40;
	localparam int CLK_MHZ = 25;
	localparam int PLL_LOCK_US = 100;
	localparam int LOCK_CYC_I = PLL_LOCK_US * CLK_MHZ;
	localparam logic [11:0] LOCK_CYC = 12'(LOCK_CYC_I);
	localparam int STOP_NS = 30;
	localparam int STOP_CYC_I = (STOP_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [3:0] STOP_CYC =
		4'((STOP_CYC_I < 1) ? 1 : STOP_CYC_I);
	// Reset values
	localparam logic [IN_W-1:0] SYNC_RST = '0;
	localparam logic [DATA_W-1:0] Q_RST = 36'h0_0000_0000;
	localparam logic Q_OE_N_RST = 1'b1;
	typedef enum logic [0:0] {
		BSP_WR_IDLE = 1'b0,
		BSP_WR_HALF = 1'b1
	} bsp_wr_e;
endpackage : bsp_pkg

// ==== design/bsp_fifo_if.sv ====
// Valid/ready carrier between the port controller and its write queue
`timescale 1ns/1ps
`default_nettype none
interface bsp_fifo_if #(parameter int W = 8);
	logic in_valid;
	logic in_ready;
	logic [W-1:0] in_data;
	logic out_valid;
	logic out_ready;
	logic [W-1:0] out_data;
	modport fifo (input in_valid, input in_data, output in_ready,
		output out_valid, output out_data, input out_ready);
	modport user (output in_valid, output in_data, input in_ready,
		input out_valid, input out_data, output out_ready);
endinterface : bsp_fifo_if
`default_nettype wire

// ==== design/bsp_fifo.sv ====
// Flip-flop FIFO with valid and ready on both sides
`timescale 1ns/1ps
`default_nettype none
module bsp_fifo #(
	parameter int W = 8,
	parameter int DEPTH = 32
) (
	input wire logic clk,
	input wire logic reset_n,
	bsp_fifo_if.fifo fif
);
	localparam int PW = $clog2(DEPTH);
	localparam int CW = $clog2(DEPTH + 1);
	logic [W-1:0] mem_q [DEPTH];
	logic [W-1:0] mem_d [DEPTH];
	logic [PW-1:0] wp_q, wp_d, rp_q, rp_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic push, pop;

	assign fif.in_ready = (cnt_q != CW'(DEPTH));
	assign fif.out_valid = (cnt_q != '0);
	assign fif.out_data = mem_q[rp_q];
	assign push = fif.in_valid && fif.in_ready;
	assign pop = fif.out_valid && fif.out_ready;

	always_comb begin
		mem_d = mem_q;
		wp_d = wp_q;
		rp_d = rp_q;
		cnt_d = cnt_q;
		if (push) begin
			mem_d[wp_q] = fif.in_data;
			wp_d = PW'(wp_q + 1'b1);
		end
		if (pop) begin
			rp_d = PW'(rp_q + 1'b1);
		end
		if (push && !pop) begin
			cnt_d = CW'(cnt_q + 1'b1);
		end else if (pop && !push) begin
			cnt_d = CW'(cnt_q - 1'b1);
		end
	end

	always_ff @(posedge clk) begin
		if (!reset_n) begin
			wp_q <= '0;
			rp_q <= '0;
			cnt_q <= '0;
		end else begin
			wp_q <= wp_d;
			rp_q <= rp_d;
			cnt_q <= cnt_d;
		end
		mem_q <= mem_d;
	end
endmodule : bsp_fifo
`default_nettype wire

// ==== verification/bsp_port_props.sv ====
// Port checks for the burst memory port controller
`timescale 1ns/1ps
`default_nettype none
module bsp_port_props (
	input wire logic clk,
	input wire logic reset_n,
	input wire logic k,
	input wire logic k_n,
	input wire logic pll_disable_pin,
	input wire logic read_port_select_n,
	input wire logic [bsp_pkg::DATA_W-1:0] q,
	input wire logic q_oe_n,
	input wire logic pll_locked,
	input wire logic wr_ready
);
	logic kp, knp, mv;
	int hi_c, run_c, rd_age, st_c;
	assign mv = (k != kp) || (k_n != knp);
	always_ff @(posedge clk) begin
		kp <= k;
		knp <= k_n;
		hi_c <= (!reset_n || !pll_disable_pin) ? 0 : hi_c + 1;
		run_c <= (!reset_n || !pll_disable_pin || !mv) ? 0 : run_c + 1;
		st_c <= mv ? 0 : st_c + 1;
		if (!reset_n)
			rd_age <= 99;
		else if (k && !kp && !read_port_select_n)
			rd_age <= 0;
		else if (mv && rd_age < 99)
			rd_age <= rd_age + 1;
	end
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	a_reset_idle: assert property (disable iff (1'b0)
		!reset_n |=> q == '0 && q_oe_n && !pll_locked && !wr_ready)
		else $error("outputs not idle after reset");
	a_q_driven: assert property ($changed(q) |-> !q_oe_n)
		else $error("read data moved while not driven");
	a_lock_min: assert property ($rose(pll_locked) |-> hi_c >= 2496)
		else $error("lock came too early");
	a_lock_max: assert property (run_c == 2515 |-> pll_locked)
		else $error("lock missing after stable clock");
	a_stop_unlock: assert property (
		pll_locked && !mv |-> ##[1:4] !pll_locked)
		else $error("stopped clock kept lock");
	a_read_start: assert property (
		$fell(q_oe_n) |-> rd_age inside {[2:9]})
		else $error("output driven without a read");
	a_read_release: assert property (rd_age == 12 |-> q_oe_n)
		else $error("output not released");
	a_stop_hold: assert property (
		st_c >= 4 |-> $stable(q) && $stable(q_oe_n))
		else $error("outputs moved while clocks stopped");
	c_lock: cover property ($rose(pll_locked));
	c_read: cover property ($fell(q_oe_n));
	c_stop: cover property (st_c == 3);
endmodule : bsp_port_props
bind bsp_port_ctrl bsp_port_props u_props (.clk, .reset_n, .k, .k_n,
	.pll_disable_pin, .read_port_select_n, .q, .q_oe_n, .pll_locked,
	.wr_ready);
`default_nettype wire

// ==== verification/bsp_ctl_model.sv ====
// Memory controller model driving the input clocks and port pins
`timescale 1ns/1ps
`default_nettype none
module bsp_ctl_model (
	input wire logic clk,
	output logic k,
	output logic k_n,
	output logic read_port_select_n,
	output logic write_port_select_n,
	output logic [3:0] addr,
	output logic [35:0] d,
	output logic [3:0] byte_write_select_n
);
	logic run = 1'b1;
	initial begin
		{k, k_n, read_port_select_n, write_port_select_n} = 4'hf;
		addr = 4'h0;
		d = 36'h0;
		byte_write_select_n = 4'hf;
	end
	always @(negedge clk) begin
		if (run) begin
			k <= ~k;
			k_n <= k;
		end else begin
			k <= 1'b1;
			k_n <= 1'b1;
		end
	end
	task automatic halt(input int n);
		@(posedge clk);
		run = 1'b0;
		repeat (n) @(posedge clk);
		run = 1'b1;
	endtask : halt
	task automatic op(input logic rd, wr, input logic [3:0] a,
		input logic [35:0] w0, w1, input logic [3:0] m0, m1);
		@(negedge clk);
		while (k !== 1'b0) @(negedge clk);
		read_port_select_n <= ~rd;
		write_port_select_n <= ~wr;
		addr <= a;
		d <= w0;
		byte_write_select_n <= m0;
		@(negedge clk);
		{read_port_select_n, write_port_select_n} <= 2'h3;
		d <= w1;
		byte_write_select_n <= m1;
		@(negedge clk);
		addr <= ~a;
		d <= ~w1;
		byte_write_select_n <= 4'hf;
	endtask : op
endmodule : bsp_ctl_model
`default_nettype wire

// ==== verification/burst_sram_port_control_tb_top.sv ====
// Random and corner tests of the burst memory port controller
`timescale 1ns/1ps
`default_nettype none
module burst_sram_port_control_tb_top;
	logic clk = 1'b0;
	logic reset_n = 1'b0;
	logic pll_disable_pin = 1'b0;
	logic cfg_x18 = 1'b0;
	wire logic k, k_n, read_port_select_n, write_port_select_n;
	wire logic [3:0] addr, byte_write_select_n;
	wire logic [35:0] d;
	logic [35:0] q;
	logic q_oe_n, pll_locked, wr_ready;
	logic [35:0] mem_exp [16];
	int num_errors = 0, checks = 0, cyc = 0, lat_l, lat_p;
	int seed = 32'h1686;
	always #20 clk = ~clk;
	bsp_ctl_model ctl (.clk, .k, .k_n, .read_port_select_n,
		.write_port_select_n, .addr, .d, .byte_write_select_n);
	bsp_port_ctrl dut (.clk, .reset_n, .k, .k_n, .pll_disable_pin,
		.cfg_x18, .read_port_select_n, .write_port_select_n, .addr, .d,
		.byte_write_select_n, .q, .q_oe_n, .pll_locked, .wr_ready);
	task automatic chk(input logic [35:0] got, exp);
		checks++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	function automatic logic [35:0] rnd();
		return 36'({$random(seed), $random(seed)});
	endfunction : rnd
	function automatic logic [35:0] merge(logic [35:0] o, n, logic [3:0] m);
		merge = o;
		for (int i = 0; i < 4; i++)
			if (!m[i] && !(cfg_x18 && i > 1))
				merge[9*i+:9] = n[9*i+:9];
	endfunction : merge
	task automatic wr(input logic [3:0] a, input logic [35:0] w0, w1,
		input logic [3:0] m0, m1);
		ctl.op(1'b0, 1'b1, a, w0, w1, m0, m1);
		mem_exp[a] = merge(mem_exp[a], w0, m0);
		mem_exp[4'(a + 1)] = merge(mem_exp[4'(a + 1)], w1, m1);
		repeat (6) @(negedge clk);
	endtask : wr
	task automatic rd(input logic [3:0] a, output int n);
		logic [35:0] m;
		n = 0;
		ctl.op(1'b1, 1'b0, a, '0, '0, 4'hf, 4'hf);
		while (q_oe_n !== 1'b0 && n < 20) begin
			@(negedge clk);
			n++;
		end
		m = cfg_x18 ? 36'h0_0003_ffff : '1;
		chk(q, mem_exp[a] & m);
		@(negedge clk);
		chk(q, mem_exp[4'(a + 1)] & m);
		repeat (8) @(negedge clk);
	endtask : rd
	task automatic tally_and_finish();
		if (num_errors == 0 && checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : tally_and_finish
	always @(posedge clk) begin
		cyc++;
		if (cyc == 8000) begin
			num_errors++;
			tally_and_finish();
		end
	end
	initial begin
		logic [3:0] a, m0, m1;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		@(negedge clk);
		chk(q, '0);
		chk(36'(q_oe_n), 36'h1);
		chk(36'(wr_ready), 36'h1);
		for (int i = 0; i < 16; i++)
			wr(4'(i), rnd(), rnd(), 4'h0, 4'h0);
		for (int i = 0; i < 40; i++) begin
			cfg_x18 = (i >= 28);
			repeat (3) @(negedge clk);
			a = (i == 1) ? 4'hf : 4'($random(seed));
			m0 = (i == 0) ? 4'hf : 4'($random(seed));
			m1 = (i == 0) ? 4'h0 : 4'($random(seed));
			wr(a, rnd(), rnd(), m0, m1);
			rd(a, lat_l);
		end
		pll_disable_pin = 1'b1;
		repeat (2400) @(negedge clk);
		chk(36'(pll_locked), 36'h0);
		for (int i = 0; i < 200 && pll_locked !== 1'b1; i++) @(negedge clk);
		chk(36'(pll_locked), 36'h1);
		rd(4'h3, lat_p);
		chk(36'(lat_p - lat_l), 36'h3);
		ctl.halt(6);
		@(negedge clk);
		chk(36'(pll_locked), 36'h0);
		ctl.op(1'b1, 1'b0, 4'h3, '0, '0, 4'hf, 4'hf);
		repeat (12) @(negedge clk);
		chk(36'(q_oe_n), 36'h1);
		reset_n = 1'b0;
		repeat (2) @(negedge clk);
		reset_n = 1'b1;
		pll_disable_pin = 1'b0;
		rd(4'h3, lat_l);
		tally_and_finish();
	end
endmodule : burst_sram_port_control_tb_top
`default_nettype wire
